//--- alu_flag_pkg.sv
// package: alu flag register field layout, widths and carriers
package alu_flag_pkg;
  localparam int DATA_W        = 8;             // data-memory word width
  localparam int FLAG_W        = 5;             // implemented flag bits
  localparam int BIT_CARRY     = 0;             // carry / borrow
  localparam int BIT_DCARRY    = 1;             // digit carry / digit borrow
  localparam int BIT_ZERO      = 2;             // zero
  localparam int BIT_OVF       = 3;             // overflow
  localparam int BIT_NEG       = 4;             // negative
  localparam int NIB_W         = 4;             // nibble width for digit carry
  localparam logic [7:0] UNIMP_MASK = 8'he0;    // bits 7..5 read as zero
  localparam logic [4:0] FLAGS_ALL  = 5'h1f;    // all five flags
  localparam logic [4:0] FLAGS_NONE = 5'h00;
  localparam logic [4:0] FLAG_Z_ONLY = 5'h04;   // zero flag alone

  // instruction classes seen by the flag logic
  typedef enum logic [2:0] {
    OP_NONE,        // no flag effect, no write to this register
    OP_ADD,         // add, all five flags
    OP_SUB,         // subtract by two's complement add
    OP_LOGIC,       // logic op, n and z only
    OP_CLEAR,       // clear_register_instr
    OP_NOFLAG       // bit set/clear, swap, moves: plain data write
  } op_class_t;

  // one instruction's request to the flag register
  typedef struct packed {
    op_class_t        op;       // class of operation
    logic [7:0]       opa;      // first operand
    logic [7:0]       opb;      // second operand
    logic             dest_sel; // destination is the flag register
    logic [7:0]       wdata;    // data to write when it is a plain write
  } alu_req_t;
endpackage : alu_flag_pkg

//--- alu_flag_register_logic.sv
// module: flag register of the alu with its update and data-write priority
`timescale 1ns/1ps

// How it works
// RULE1 - register readable and writable like any other
// RULE2 - flag updates override data write to flags
// RULE3 - clear aimed here gives 000u uluu
// RULE4 - bit ops, swap, moves leave flags alone
// RULE5 - subtract: carry flags are inverted borrows
// RULE6 - bits 7..5 unimplemented, read zero
module alu_flag_register_logic
  import alu_flag_pkg::*;
(
  input  wire logic            i_clk,      // instruction clock
  input  wire logic            i_reset_n,  // async reset, active low
  input  wire alu_req_t        i_req,      // instruction request
  output logic [DATA_W-1:0]    o_rdata,    // register read value
  output logic [DATA_W-1:0]    o_result    // alu result
);

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic
  logic [FLAG_W-1:0] flags;                 // flag storage, no reset value
  logic [DATA_W-1:0] opb_eff;               // second operand after complement
  logic [DATA_W:0]   sum;                   // full sum with carry out
  logic [NIB_W:0]    nib_sum;               // low nibble sum with carry out
  logic              is_arith;              // add or subtract
  logic              is_sub;                // subtract
  logic [DATA_W-1:0] res;                   // operation result
  logic [FLAG_W-1:0] calc;                  // flags from the result
  logic [FLAG_W-1:0] upd_mask;              // flags the operation touches
  logic [FLAG_W-1:0] next_flags;            // next flag value
  logic              plain_write;           // exact data write into the flags
  logic              flag_update;           // this op drives at least one flag
  logic [DATA_W-1:0] read_word;             // flags widened to a data word

  // logic ops report sign and zero only
  localparam logic [FLAG_W-1:0] FLAGS_NZ = FLAG_Z_ONLY | (FLAG_W'(1) << BIT_NEG);

  // zero test used for both the result and the clear path
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction : is_zero

  assign is_sub   = (i_req.op == OP_SUB);
  assign is_arith = (i_req.op == OP_ADD) || is_sub;
  // subtract adds the two's complement, so carry means no borrow [RULE5]
  assign opb_eff  = is_sub ? ~i_req.opb : i_req.opb;
  assign sum      = {1'b0, i_req.opa} + {1'b0, opb_eff} + {{DATA_W{1'b0}}, is_sub};
  assign nib_sum  = {1'b0, i_req.opa[NIB_W-1:0]} + {1'b0, opb_eff[NIB_W-1:0]}
                  + {{NIB_W{1'b0}}, is_sub};
  assign res = (i_req.op == OP_LOGIC) ? (i_req.opa & i_req.opb) :
               (i_req.op == OP_CLEAR) ? '0 :
               is_arith ? sum[DATA_W-1:0] : i_req.wdata;

  // flag values computed from the result
  always_comb begin
    calc             = flags;
    calc[BIT_NEG]    = res[DATA_W-1];
    calc[BIT_ZERO]   = is_zero(res);
    calc[BIT_OVF]    = (i_req.opa[DATA_W-1] == opb_eff[DATA_W-1])
                     && (res[DATA_W-1] != i_req.opa[DATA_W-1]);
    calc[BIT_CARRY]  = sum[DATA_W];        // [RULE5]
    calc[BIT_DCARRY] = nib_sum[NIB_W];     // [RULE5]
  end

  // which flags each class drives; plain writers touch none [RULE4]
  always_comb begin
    unique case (i_req.op)
      OP_ADD, OP_SUB: upd_mask = FLAGS_ALL;
      OP_LOGIC:       upd_mask = FLAGS_NZ;
      OP_CLEAR:       upd_mask = FLAG_Z_ONLY;   // [RULE3]
      default:        upd_mask = FLAGS_NONE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next flag value: flag logic wins over data write
  // plain writers aimed here store the low five bits exactly [RULE4]
  assign plain_write = i_req.dest_sel && (i_req.op == OP_NOFLAG);
  // any class with a non-empty mask blocks the data write [RULE2]
  assign flag_update = (upd_mask != FLAGS_NONE);

  always_comb begin
    next_flags = flags;
    if (plain_write) begin
      next_flags = i_req.wdata[FLAG_W-1:0];             // [RULE1] [RULE4]
    end else if (flag_update) begin
      // data write to the five bits suppressed; result flags taken [RULE2]
      next_flags = (flags & ~upd_mask) | (calc & upd_mask);
    end
  end

  // flags hold no reset value; only the read and result ports reset
  // limitation: after power-up the flags are unknown until first written,
  // traded for a register with no reset tree on its five bits
  always_ff @(posedge i_clk) begin
    flags <= next_flags;
  end

  // read word: upper bits are never stored, so they cannot read back as ones
  assign read_word = {{(DATA_W-FLAG_W){1'b0}}, next_flags};   // [RULE6]

  // registered read and result; upper bits of the read forced to zero [RULE6]
  // the read shows this edge's update, so a source operand sees fresh flags [RULE1]
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata  <= '0;
      o_result <= '0;
    end else begin
      o_rdata  <= read_word & ~UNIMP_MASK;              // [RULE1] [RULE6]
      o_result <= res;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // every antecedent but a_noflag_other's also asks for reset high at the sampling edge: on the
  // edge that releases reset the outputs are still held at zero, so an
  // attempt started there would compare against a cleared read port
  sequence s_clear_here;
    i_reset_n && i_req.op == OP_CLEAR && i_req.dest_sel;
  endsequence

  // add or subtract whose destination is this register
  sequence s_arith_here;
    i_reset_n && (i_req.op == OP_ADD || i_req.op == OP_SUB) && i_req.dest_sel;
  endsequence

  // logic op, wherever its result goes
  sequence s_logic_here;
    i_reset_n && i_req.op == OP_LOGIC;
  endsequence

  // clear aimed here: upper bits zero, zero flag set, sign kept
  a_clear_sets_zero: // [RULE3]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_clear_here |=> o_rdata[BIT_ZERO] && o_rdata[7:5] == 3'h0
        && o_rdata[BIT_NEG] == $past(flags[BIT_NEG]))
    else $error("clear did not give expected pattern");

  // a plain writer aimed here stores its low five bits exactly
  a_noflag_write: // [RULE4]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n && i_req.op == OP_NOFLAG && i_req.dest_sel
        |=> o_rdata[4:0] == $past(i_req.wdata[4:0]))
    else $error("plain write not stored exactly");

  // a plain writer aimed elsewhere leaves the flags alone
  a_noflag_other: // [RULE4]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_req.op == OP_NOFLAG && !i_req.dest_sel |=> $stable(flags))
    else $error("flags changed by non-flag op");

  // zero flag after an add follows the registered result
  a_add_wins: // [RULE2]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n && i_req.op == OP_ADD |=> o_rdata[BIT_ZERO] == (o_result == 8'h00))
    else $error("zero flag does not match result");

  // subtract: carry set means no borrow
  a_sub_borrow: // [RULE5]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n && i_req.op == OP_SUB
        |=> o_rdata[BIT_CARRY] == ($past(i_req.opa) >= $past(i_req.opb)))
    else $error("borrow polarity wrong");

  // the three unimplemented bits never read as one
  a_upper_zero: // [RULE6]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_rdata[7:5] == 3'h0)
    else $error("unimplemented bits read nonzero");

  // clear leaves overflow, digit carry and carry where they were
  a_clear_keeps_rest: // [RULE3]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_clear_here |=> o_rdata[BIT_OVF] == $past(flags[BIT_OVF])
        && o_rdata[BIT_DCARRY] == $past(flags[BIT_DCARRY])
        && o_rdata[BIT_CARRY] == $past(flags[BIT_CARRY]))
    else $error("clear changed a flag it must keep");

  // an arithmetic op aimed here stores its own flags, never the data word
  a_arith_dest: // [RULE2]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_arith_here |=> o_rdata[BIT_ZERO] == (o_result == '0)
        && o_rdata[BIT_NEG] == o_result[DATA_W-1])
    else $error("data write reached the flags");

  // logic ops leave overflow and both carries alone
  a_logic_keeps: // [RULE2]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_logic_here |=> o_rdata[BIT_OVF] == $past(flags[BIT_OVF])
        && o_rdata[BIT_DCARRY] == $past(flags[BIT_DCARRY])
        && o_rdata[BIT_CARRY] == $past(flags[BIT_CARRY]))
    else $error("logic op changed a carry or overflow");

  // carry out of an add shows as a result below the first operand
  a_add_carry: // [RULE2]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n && i_req.op == OP_ADD
        |=> o_rdata[BIT_CARRY] == (o_result < $past(i_req.opa)))
    else $error("add carry wrong");

  // subtract: digit carry set means the low nibble did not borrow
  a_sub_digit: // [RULE5]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n && i_req.op == OP_SUB
        |=> o_rdata[BIT_DCARRY]
          == ($past(i_req.opa[NIB_W-1:0]) >= $past(i_req.opb[NIB_W-1:0])))
    else $error("digit borrow polarity wrong");

  // adding the complement must still give the plain difference
  a_sub_result: // [RULE5]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n && i_req.op == OP_SUB
        |=> o_result == DATA_W'($past(i_req.opa) - $past(i_req.opb)))
    else $error("difference wrong");

  // an OP_NONE request leaves the stored flags where they were
  a_none_holds: // [RULE4]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n && i_req.op == OP_NONE |=> o_rdata[FLAG_W-1:0] == $past(flags))
    else $error("flags moved without a flag op");

  // the read port mirrors the stored flags on the same edge, with no lag
  a_read_mirror: // [RULE1]
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_reset_n |=> o_rdata[FLAG_W-1:0] == flags)
    else $error("read value differs from stored flags");

endmodule : alu_flag_register_logic

//--- alu_flag_register_logic_bench.sv
// testbench: flag register driven with corner and random requests
`timescale 1ns/1ps
module alu_flag_register_logic_bench;
  import alu_flag_pkg::*;
  logic        i_clk = 1'b0;     // instruction clock
  logic        i_reset_n = 1'b0; // async reset, active low
  alu_req_t    i_req;            // request under test
  logic [7:0]  o_rdata;          // flag read value
  logic [7:0]  o_result;         // alu result
  logic [15:0] pend = '0;        // expected {flags, result} of last request
  logic [31:0] v;                // random word
  alu_req_t    r;                // random request
  int          seed = 40082;
  int          error_cnt = 0;
  int          checked = 0;

  always #5 i_clk = ~i_clk;

  alu_flag_register_logic dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
                               .o_rdata(o_rdata), .o_result(o_result));

  ////////////////////////////////////////////////////////////////////////////////
  // model of next {flags, result}; upper three bits always zero
  function automatic logic [15:0] model(alu_req_t q, logic [7:0] f);
    logic [7:0] b;
    logic [8:0] s;
    logic [4:0] h;
    logic       ci;
    ci = (q.op == OP_SUB);
    b  = ci ? ~q.opb : q.opb; // subtract adds the two's complement
    s  = q.opa + b + ci;
    h  = q.opa[3:0] + b[3:0] + ci;
    case (q.op)
      OP_ADD, OP_SUB: return {3'h0, s[7], (q.opa[7] == b[7]) && (s[7] != q.opa[7]),
                              s[7:0] == 8'h00, h[4], s[8], s[7:0]};
      OP_LOGIC: begin
        s[7:0] = q.opa & q.opb;
        return {3'h0, s[7], f[3], s[7:0] == 8'h00, f[1:0], s[7:0]};
      end
      OP_CLEAR:  return {f[7:3], 1'b1, f[1:0], 8'h00};
      OP_NOFLAG: return {q.dest_sel ? {3'h0, q.wdata[4:0]} : f, q.wdata};
      default:   return {f, q.wdata};
    endcase
  endfunction : model

  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // drive one request; compare what the previous one left
  task automatic step(alu_req_t q);
    @(posedge i_clk);
    i_req <= q;
    @(negedge i_clk);
    check("flags", o_rdata, pend[15:8]);
    check("result", o_result, pend[7:0]);
    pend = model(q, pend[15:8]);
  endtask : step

  // reset in mid-run: outputs clear, the flag bits keep their value
  task automatic pulse_reset();
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_req     <= '{OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00};
    @(negedge i_clk);
    check("rdata in reset", o_rdata, 8'h00);
    check("result in reset", o_result, 8'h00);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    pend = model('{OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00}, pend[15:8]);
  endtask : pulse_reset

  task results();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // flags have no reset, so the first request writes them plainly
  initial begin
    i_req = '{OP_NOFLAG, 8'h00, 8'h00, 1'b1, 8'h00};
    repeat (6) @(posedge i_clk);
    check("reset", o_rdata, 8'h00);
    i_reset_n <= 1'b1;
    step('{OP_NOFLAG, 8'h00, 8'h00, 1'b1, 8'hfb});
    step('{OP_CLEAR, 8'h00, 8'h00, 1'b1, 8'hff});
    step('{OP_ADD, 8'h7f, 8'h01, 1'b1, 8'h00});
    step('{OP_SUB, 8'h10, 8'h20, 1'b1, 8'hff});
    step('{OP_SUB, 8'h20, 8'h20, 1'b1, 8'h00});
    step('{OP_ADD, 8'hff, 8'h01, 1'b1, 8'h1f});
    step('{OP_LOGIC, 8'h80, 8'hc0, 1'b1, 8'h00});
    step('{OP_SUB, 8'h00, 8'h01, 1'b0, 8'h00});
    step('{OP_CLEAR, 8'h00, 8'h00, 1'b0, 8'h00});
    for (int k = 0; k < 400; k++) begin
      if (k == 200) begin
        pulse_reset();
      end
      v = $random(seed);
      r = v[27:0];
      r.op = op_class_t'(v[30:28] > 3'h5 ? 3'h5 : v[30:28]); // legal classes only
      step(r);
    end
    step('{OP_NONE, 8'h00, 8'h00, 1'b0, 8'h00});
    results();
  end
endmodule : alu_flag_register_logic_bench
